/* common/deac_params.svh */
// Purpose: Offsets, bit positions, reset values and timing of the EEPROM control block
// Assumes: APB byte addresses, 32-bit data, 25 MHz pclk
// Notes:   Included by the design, checker and bench files
`ifndef DEAC_PARAMS_SVH
`define DEAC_PARAMS_SVH
// Register byte offsets
`define DEAC_OFF_CTRL      8'h00
`define DEAC_OFF_ADDR_LOW  8'h04
`define DEAC_OFF_ADDR_UP   8'h08
`define DEAC_OFF_KEY       8'h0c
`define DEAC_OFF_PAGE      8'h10
`define DEAC_OFF_PTR       8'h14
`define DEAC_OFF_TDATA     8'h18
`define DEAC_OFF_IFS       8'h1c
// Control and done-flag bit positions
`define DEAC_BIT_START     15
`define DEAC_BIT_WEN       14
`define DEAC_BIT_ABORT     13
`define DEAC_BIT_ERASE     6
`define DEAC_OP_MSB        3
`define DEAC_BIT_DONE      0
// Operation codes in the op field
`define DEAC_OP_WORD       4'h4
`define DEAC_OP_BLK_ERASE  4'h5
`define DEAC_OP_BLK_PROG   4'ha
// Unlock keys
`define DEAC_KEY_FIRST     8'h55
`define DEAC_KEY_SECOND    8'haa
// Array window in program space
`define DEAC_EE_FIRST      24'h7ff000
`define DEAC_EE_LAST       24'h7ffffe
`define DEAC_ERASED        16'hffff
// Reset values
`define DEAC_RST_OP        4'h0
`define DEAC_RST_WORD      16'h0000
`define DEAC_RST_BYTE      8'h00
// Timing
`define DEAC_PCLK_NS       40
`define DEAC_CYCLE_NS      2000000
`define DEAC_CYCLE_CLKS    (`DEAC_CYCLE_NS / `DEAC_PCLK_NS)
`endif

/* common/deac_pkg.sv */
// Purpose: Types of the EEPROM control block
// Assumes: Nothing
// Notes:   Values live in deac_params.svh
package deac_pkg;
    typedef enum logic [1:0] {
        DEAC_KEY_LOCKED,
        DEAC_KEY_HALF,
        DEAC_KEY_OPEN
    } deac_key_t;

    typedef enum logic [2:0] {
        DEAC_RUN_NONE,
        DEAC_RUN_WORD_PROG,
        DEAC_RUN_WORD_ERASE,
        DEAC_RUN_BLK_PROG,
        DEAC_RUN_BLK_ERASE
    } deac_run_t;
endpackage

/* rtl/deac_cycle_timer.sv */
// Purpose: Times one program or erase cycle
// Assumes: start only while idle
// Notes:   abort stops the count with no done pulse
`timescale 1ns/1ps
module deac_cycle_timer #(
    parameter int CLKS = 50000
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic start,
    input  wire logic abort,
    // Status
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(CLKS + 1);
    localparam logic [CW-1:0] LAST = CW'(CLKS - 1);

    logic [CW-1:0] count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy  <= 1'b0;
            count <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy  <= 1'b0;
                count <= '0;
            end else if (start && !busy) begin
                busy  <= 1'b1;
                count <= '0;
            end else if (busy) begin
                if (count == LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule

/* rtl/deac_ee_array.sv */
// Purpose: Data EEPROM word array with word and block update
// Assumes: One update per cycle
// Notes:   Program can only clear bits; erase sets a word to all ones
`timescale 1ns/1ps
`include "deac_params.svh"
module deac_ee_array #(
    parameter int DEPTH = 4096,
    parameter int WIDTH = 16,
    parameter int BLOCK = 16
) (
    // Clock
    input  wire logic                     pclk,
    // Read port
    input  wire logic [11:0]              rd_idx,
    output logic [WIDTH-1:0]              rd_data,
    // Update port
    input  wire logic                     wr_en,
    input  wire logic                     wr_erase,
    input  wire logic                     wr_block,
    input  wire logic [11:0]              wr_idx,
    input  wire logic [BLOCK*WIDTH-1:0]   wr_latch
);
    logic [WIDTH-1:0] mem [DEPTH];

    assign rd_data = mem[rd_idx];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            for (int i = 0; i < BLOCK; i++) begin
                if (wr_block || (wr_idx[3:0] == 4'(i))) begin
                    if (wr_erase)
                        mem[{wr_idx[11:4], 4'(i)}] <= `DEAC_ERASED;
                    else
                        mem[{wr_idx[11:4], 4'(i)}] <= mem[{wr_idx[11:4], 4'(i)}]
                                                       & wr_latch[i*WIDTH +: WIDTH];
                end
            end
        end
    end
endmodule

/* rtl/deac_nv_ctrl.sv */
// Purpose: Data EEPROM access control behind an APB slave
// Assumes: 25 MHz pclk; reset pin arrives from outside the clock domain
// Notes:   Cycles run in the background; the bus never waits on them
`timescale 1ns/1ps
`include "deac_params.svh"

module deac_nv_ctrl #(
    parameter int CYCLE_CLKS = `DEAC_CYCLE_CLKS,
    parameter int DEPTH      = 4096,
    parameter int BLOCK      = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Warm reset sources
    input  wire logic        master_clear_reset_pin_n,
    input  wire logic        watchdog_timeout,
    // Status
    output logic             op_busy,
    output logic             nv_done_irq_flag
);
    logic               ctrl_start;
    logic               write_enable_bit;
    logic               op_abort_flag;
    logic               ctrl_erase;
    logic [3:0]         ctrl_op;
    logic [15:0]        nv_addr_low_reg;
    logic [7:0]         nv_addr_upper_reg;
    logic [7:0]         table_page_reg;
    logic [15:0]        table_ptr;
    deac_pkg::deac_key_t key_state;
    deac_pkg::deac_run_t run_kind;
    deac_pkg::deac_run_t next_run;
    logic [11:0]        run_idx;
    logic [BLOCK*16-1:0] latch_bus;
    logic [15:0]        latch [BLOCK];
    logic               master_clear_reset_pin_s1;
    logic               master_clear_reset_pin_s2;
    logic               master_clear_reset_pin_s3;
    logic               master_clear_reset_pin_level;
    logic               master_clear_reset_pin_fall;
    logic               warm;
    logic               acc;
    logic               wr;
    logic               timer_busy;
    logic               timer_done;
    logic               start_go;
    logic               tbl_in_range;
    logic               ee_in_range;
    logic [15:0]        rd_word;
    logic [31:0]        next_rdata;
    logic               next_err;

    // Reset pin filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_clear_reset_pin_s1    <= 1'b1;
            master_clear_reset_pin_s2    <= 1'b1;
            master_clear_reset_pin_s3    <= 1'b1;
            master_clear_reset_pin_level <= 1'b1;
        end else begin
            master_clear_reset_pin_s1 <= master_clear_reset_pin_n;
            master_clear_reset_pin_s2 <= master_clear_reset_pin_s1;
            master_clear_reset_pin_s3 <= master_clear_reset_pin_s2;
            if (master_clear_reset_pin_s2 == master_clear_reset_pin_s3)
                master_clear_reset_pin_level <= master_clear_reset_pin_s2;
        end
    end

    assign master_clear_reset_pin_fall = master_clear_reset_pin_level && (master_clear_reset_pin_s2 == master_clear_reset_pin_s3) && !master_clear_reset_pin_s2;
    assign warm      = master_clear_reset_pin_fall || watchdog_timeout;

    // APB handshake
    assign acc = psel && penable && !pready;
    assign wr  = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= acc;
    end

    // Address windows
    assign tbl_in_range = ({table_page_reg, table_ptr} >= `DEAC_EE_FIRST)
                        && ({table_page_reg, table_ptr} <= `DEAC_EE_LAST);
    assign ee_in_range  = ({nv_addr_upper_reg, nv_addr_low_reg} >= `DEAC_EE_FIRST)
                        && ({nv_addr_upper_reg, nv_addr_low_reg} <= `DEAC_EE_LAST);

    // Mode decode
    always_comb begin
        next_run = deac_pkg::DEAC_RUN_NONE;
        if (pwdata[`DEAC_BIT_ERASE] && pwdata[`DEAC_OP_MSB:0] == `DEAC_OP_BLK_ERASE)
            next_run = deac_pkg::DEAC_RUN_BLK_ERASE;
        else if (pwdata[`DEAC_BIT_ERASE] && pwdata[`DEAC_OP_MSB:0] == `DEAC_OP_WORD)
            next_run = deac_pkg::DEAC_RUN_WORD_ERASE;
        else if (!pwdata[`DEAC_BIT_ERASE] && pwdata[`DEAC_OP_MSB:0] == `DEAC_OP_BLK_PROG)
            next_run = deac_pkg::DEAC_RUN_BLK_PROG;
        else if (!pwdata[`DEAC_BIT_ERASE] && pwdata[`DEAC_OP_MSB:0] == `DEAC_OP_WORD)
            next_run = deac_pkg::DEAC_RUN_WORD_PROG;
    end

    // Start qualification
    assign start_go = wr && (paddr == `DEAC_OFF_CTRL) && pwdata[`DEAC_BIT_START]
                    && (key_state == deac_pkg::DEAC_KEY_OPEN)
                    && write_enable_bit
                    && !timer_busy && !warm && ee_in_range
                    && (next_run != deac_pkg::DEAC_RUN_NONE);

    // Unlock sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_state <= deac_pkg::DEAC_KEY_LOCKED;
        end else if (warm) begin
            key_state <= deac_pkg::DEAC_KEY_LOCKED;
        end else if (wr && paddr == `DEAC_OFF_KEY) begin
            if (pwdata[7:0] == `DEAC_KEY_FIRST)
                key_state <= deac_pkg::DEAC_KEY_HALF;
            else if (pwdata[7:0] == `DEAC_KEY_SECOND
                     && key_state == deac_pkg::DEAC_KEY_HALF)
                key_state <= deac_pkg::DEAC_KEY_OPEN;
            else
                key_state <= deac_pkg::DEAC_KEY_LOCKED;
        end else if (wr && paddr == `DEAC_OFF_CTRL) begin
            key_state <= deac_pkg::DEAC_KEY_LOCKED;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_enable_bit <= 1'b0;
            ctrl_erase       <= 1'b0;
            ctrl_op          <= `DEAC_RST_OP;
        end else if (warm) begin
            write_enable_bit <= 1'b0;
            ctrl_erase       <= 1'b0;
            ctrl_op          <= `DEAC_RST_OP;
        end else if (wr && paddr == `DEAC_OFF_CTRL) begin
            write_enable_bit <= pwdata[`DEAC_BIT_WEN];
            ctrl_erase       <= pwdata[`DEAC_BIT_ERASE];
            ctrl_op          <= pwdata[`DEAC_OP_MSB:0];
        end
    end

    // Start bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_start <= 1'b0;
        else if (warm || (timer_done && !start_go))
            ctrl_start <= 1'b0;
        else if (start_go)
            ctrl_start <= 1'b1;
    end

    // Abort flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            op_abort_flag <= 1'b0;
        else if (warm && timer_busy)
            op_abort_flag <= 1'b1;
        else if (wr && paddr == `DEAC_OFF_CTRL)
            op_abort_flag <= pwdata[`DEAC_BIT_ABORT];
    end

    // Done flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            nv_done_irq_flag <= 1'b0;
        else if (timer_done)
            nv_done_irq_flag <= 1'b1;
        else if (wr && paddr == `DEAC_OFF_IFS)
            nv_done_irq_flag <= pwdata[`DEAC_BIT_DONE];
    end

    // Address registers, kept across warm reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_addr_low_reg   <= `DEAC_RST_WORD;
            nv_addr_upper_reg <= `DEAC_RST_BYTE;
        end else if (wr && paddr == `DEAC_OFF_ADDR_LOW) begin
            nv_addr_low_reg   <= pwdata[15:0];
        end else if (wr && paddr == `DEAC_OFF_ADDR_UP) begin
            nv_addr_upper_reg <= pwdata[7:0];
        end else if (wr && paddr == `DEAC_OFF_TDATA && tbl_in_range && !timer_busy) begin
            nv_addr_low_reg   <= table_ptr;
            nv_addr_upper_reg <= table_page_reg;
        end
    end

    // Table pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_page_reg <= `DEAC_RST_BYTE;
            table_ptr      <= `DEAC_RST_WORD;
        end else if (wr && paddr == `DEAC_OFF_PAGE) begin
            table_page_reg <= pwdata[7:0];
        end else if (wr && paddr == `DEAC_OFF_PTR) begin
            table_ptr      <= pwdata[15:0];
        end
    end

    // Write latches
    generate
        for (genvar g = 0; g < BLOCK; g++) begin : g_latch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    latch[g] <= `DEAC_ERASED;
                else if (wr && paddr == `DEAC_OFF_TDATA && tbl_in_range && !timer_busy
                         && table_ptr[3:0] == 4'(g))
                    latch[g] <= pwdata[15:0];
            end
            assign latch_bus[g*16 +: 16] = latch[g];
        end
    endgenerate

    // Running operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_kind <= deac_pkg::DEAC_RUN_NONE;
            run_idx  <= 12'h000;
        end else if (start_go) begin
            run_kind <= next_run;
            run_idx  <= nv_addr_low_reg[11:0];
        end
    end

    deac_cycle_timer #(
        .CLKS (CYCLE_CLKS)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start_go),
        .abort   (warm),
        .busy    (timer_busy),
        .done    (timer_done)
    );

    deac_ee_array #(
        .DEPTH (DEPTH),
        .WIDTH (16),
        .BLOCK (BLOCK)
    ) u_array (
        .pclk     (pclk),
        .rd_idx   (table_ptr[11:0]),
        .rd_data  (rd_word),
        .wr_en    (timer_done),
        .wr_erase ((run_kind == deac_pkg::DEAC_RUN_WORD_ERASE)
                   || (run_kind == deac_pkg::DEAC_RUN_BLK_ERASE)),
        .wr_block ((run_kind == deac_pkg::DEAC_RUN_BLK_PROG)
                   || (run_kind == deac_pkg::DEAC_RUN_BLK_ERASE)),
        .wr_idx   (run_idx),
        .wr_latch (latch_bus)
    );

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (paddr)
            `DEAC_OFF_CTRL: begin
                next_rdata[`DEAC_BIT_START] = ctrl_start;
                next_rdata[`DEAC_BIT_WEN]   = write_enable_bit;
                next_rdata[`DEAC_BIT_ABORT] = op_abort_flag;
                next_rdata[`DEAC_BIT_ERASE] = ctrl_erase;
                next_rdata[`DEAC_OP_MSB:0]  = ctrl_op;
            end
            `DEAC_OFF_ADDR_LOW: next_rdata[15:0] = nv_addr_low_reg;
            `DEAC_OFF_ADDR_UP:  next_rdata[7:0]  = nv_addr_upper_reg;
            `DEAC_OFF_KEY:      next_rdata       = 32'h0000_0000;
            `DEAC_OFF_PAGE:     next_rdata[7:0]  = table_page_reg;
            `DEAC_OFF_PTR:      next_rdata[15:0] = table_ptr;
            `DEAC_OFF_TDATA: begin
                if (tbl_in_range && !timer_busy)
                    next_rdata[15:0] = rd_word;
                else
                    next_rdata[15:0] = 16'h0000;
            end
            `DEAC_OFF_IFS:      next_rdata[`DEAC_BIT_DONE] = nv_done_irq_flag;
            default:            next_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= (acc && !pwrite) ? next_rdata : 32'h0000_0000;
            pslverr <= acc && next_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            op_busy <= 1'b0;
        else
            op_busy <= (timer_busy && !warm && !timer_done) || start_go;
    end
endmodule

/* tb/deac_core_model.sv */
// Purpose: Warm reset sources around the core
// Assumes: Requests are single-cycle
// Notes:   Pin low for 15 cycles
`timescale 1ns/1ps
module deac_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests
    input wire logic wdt_req,
    input wire logic pin_req,
    // Warm reset sources
    output logic     watchdog_timeout,
    output logic     master_clear_reset_pin_n
);
    logic [3:0] hold;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) watchdog_timeout <= 1'b0;
        else watchdog_timeout <= wdt_req && !watchdog_timeout;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hold <= 4'h0;
        else if (pin_req) hold <= 4'hf;
        else if (hold != 4'h0) hold <= hold - 4'h1;
    end
    assign master_clear_reset_pin_n = (hold == 4'h0);
endmodule

/* tb/deac_nv_ctrl_assertions.sv */
// Purpose: Port checks of the EEPROM control block
// Assumes: Bound to the top module
// Notes:   Cycle length follows CYCLE_CLKS
`timescale 1ns/1ps
`include "deac_params.svh"
module deac_nv_chk #(
    parameter int CYCLE_CLKS = 50000
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Warm reset and status
    input wire logic        master_clear_reset_pin_n,
    input wire logic        watchdog_timeout,
    input wire logic        op_busy,
    input wire logic        nv_done_irq_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int unsigned bcnt;
    logic        warm;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) bcnt <= 0;
        else bcnt <= op_busy ? bcnt + 1 : 0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) warm <= 1'b0;
        else warm <= op_busy && (warm || watchdog_timeout || !master_clear_reset_pin_n);
    end
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && !pready; endsequence
    property p_one_wait; s_setup ##1 s_access |=> pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready late");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready long");
    property p_rd_busy;
        pready && !pwrite && paddr == `DEAC_OFF_TDATA && op_busy && $past(op_busy)
            |-> prdata == 32'h0;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read during cycle");
    property p_start_src;
        $rose(op_busy) |-> $past(pready && pwrite && paddr == `DEAC_OFF_CTRL && pwdata[15]);
    endproperty
    a_start_src: assert property (p_start_src) else $error("cycle without start");
    property p_busy_len;
        $fell(op_busy) && !warm |-> bcnt + 1 >= CYCLE_CLKS && bcnt <= CYCLE_CLKS + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("cycle length");
    property p_done_src;
        $rose(nv_done_irq_flag) && !$past(pready && pwrite) |-> $past(op_busy) && !$past(warm);
    endproperty
    a_done_src: assert property (p_done_src) else $error("flag without end");
    property p_flag_keep;
        $fell(nv_done_irq_flag) |-> $past(pready && pwrite && paddr == `DEAC_OFF_IFS);
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost");
    property p_wdt_abort; watchdog_timeout && op_busy |-> ##[1:3] !op_busy; endproperty
    a_wdt_abort: assert property (p_wdt_abort) else $error("wdt abort");
    property p_pin_abort;
        $fell(master_clear_reset_pin_n) && op_busy |-> ##[1:8] !op_busy;
    endproperty
    a_pin_abort: assert property (p_pin_abort) else $error("pin abort");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
endmodule
bind deac_nv_ctrl deac_nv_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear_reset_pin_n(master_clear_reset_pin_n),
    .watchdog_timeout(watchdog_timeout), .op_busy(op_busy),
    .nv_done_irq_flag(nv_done_irq_flag));

/* tb/tb_top.sv */
// Purpose: Bench of the EEPROM control block
// Assumes: Short cycle count
// Notes:   Array model kept in mem
`timescale 1ns/1ps
`include "deac_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    localparam int CC = 60;
    localparam logic [7:0] CT = `DEAC_OFF_CTRL, AL = `DEAC_OFF_ADDR_LOW, AU = `DEAC_OFF_ADDR_UP;
    localparam logic [7:0] KY = `DEAC_OFF_KEY, PG = `DEAC_OFF_PAGE, PT = `DEAC_OFF_PTR;
    localparam logic [7:0] TD = `DEAC_OFF_TDATA, FL = `DEAC_OFF_IFS;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic        pready, pslverr, erv, op_busy, flag, wdt, pin_n, wdt_req = 0, pin_req = 0;
    int          n_mismatch = 0, num_checks = 0, seed = 32'h64a49fed, mem[int];
    logic [15:0] lat[16];
    always #20 pclk = ~pclk;
    deac_nv_ctrl #(.CYCLE_CLKS(CC), .DEPTH(4096), .BLOCK(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .master_clear_reset_pin_n(pin_n), .watchdog_timeout(wdt), .op_busy(op_busy),
        .nv_done_irq_flag(flag));
    deac_core_model u_core (.pclk(pclk), .presetn(presetn), .wdt_req(wdt_req),
        .pin_req(pin_req), .watchdog_timeout(wdt), .master_clear_reset_pin_n(pin_n));
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata; erv = pslverr;
        psel <= 0; penable <= 0; paddr <= ~a; pwdata <= ~d;
        @(posedge pclk);
    endtask
    task chkw(input int i);
        apb(1, PT, 32'hf000 + i);
        apb(0, TD, 0);
        `CHK(rdv[15:0], 16'(mem[i]))
    endtask
    task start(input logic [15:0] c, input logic [15:0] s, input bit k, input logic g);
        apb(1, CT, c);
        if (k) begin
            apb(1, KY, `DEAC_KEY_FIRST);
            apb(1, KY, `DEAC_KEY_SECOND);
        end
        apb(1, CT, s);
        apb(0, CT, 0);
        `CHK(rdv[15], g)
    endtask
    task finish_op;
        do begin
            apb(0, CT, 0);
        end while (rdv[15] !== 1'b0);
        `CHK(rdv[15], 1'b0)
        `CHK(op_busy, 1'b0)
        apb(0, FL, 0);
        `CHK(rdv[0], 1'b1)
        `CHK(flag, 1'b1)
        apb(1, FL, 0);
        apb(0, FL, 0);
        `CHK(rdv[0], 1'b0)
    endtask
    task abort_op(input bit p);
        start(16'h4004, 16'hc004, 1, 1);
        if (p) pin_req <= 1;
        else wdt_req <= 1;
        @(posedge pclk);
        pin_req <= 0; wdt_req <= 0;
        repeat (20) @(posedge pclk);
        apb(0, CT, 0);
        `CHK(rdv[15:13], 3'b001)
        `CHK(op_busy, 1'b0)
        apb(0, AL, 0);
        `CHK(rdv[15:0], 16'hf011)
        chkw(17);
        apb(0, FL, 0);
        `CHK(rdv[0], 1'b0)
        apb(1, CT, 0);
        apb(0, CT, 0);
        `CHK(rdv[13], 1'b0)
    endtask
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, CT, 0);
        `CHK(rdv, 32'h0)
        apb(0, 8'h20, 0);
        `CHK(erv, 1'b1)
        apb(1, PG, 32'h7f);
        apb(1, AU, 32'h00);
        apb(1, AL, 32'hf010);
        start(16'h4044, 16'hc044, 1, 0);
        apb(1, AU, 32'h7f);
        start(16'h4044, 16'hc044, 0, 0);
        apb(1, CT, 0);
        start(16'h0044, 16'hc044, 1, 0);
        start(16'h4003, 16'hc003, 1, 0);
        start(16'h4044, 16'hc044, 1, 1);
        apb(1, CT, 32'h4044);
        apb(0, CT, 0);
        `CHK(rdv[15], 1'b1)
        `CHK(op_busy, 1'b1)
        apb(1, PT, 32'hf010);
        apb(0, TD, 0);
        `CHK(rdv, 32'h0)
        finish_op;
        mem[16] = 16'hffff;
        chkw(16);
        lat[0] = 16'($random(seed));
        apb(1, TD, lat[0]);
        start(16'h4004, 16'hc004, 1, 1);
        apb(1, CT, 32'h0004);
        finish_op;
        mem[16] = mem[16] & lat[0];
        chkw(16);
        start(16'h4045, 16'hc045, 1, 1);
        finish_op;
        for (int i = 0; i < 16; i++) begin
            mem[16 + i] = 16'hffff;
            chkw(16 + i);
        end
        for (int i = 0; i < 16; i++) begin
            lat[i] = 16'($random(seed));
            apb(1, PT, 32'hf010 + i);
            apb(1, TD, lat[i]);
        end
        start(16'h400a, 16'hc00a, 1, 1);
        finish_op;
        for (int i = 0; i < 16; i++) begin
            mem[16 + i] = mem[16 + i] & lat[i];
            chkw(16 + i);
        end
        apb(1, PT, 32'hf011);
        apb(1, TD, 32'h0);
        abort_op(0);
        abort_op(1);
        tally_and_finish;
    end
endmodule
